// ===== logic/misc_ctrl_pkg.sv
package misc_ctrl_pkg;
    localparam logic [7:0] MISC_CTRL_INDEX = 8'h39;
    localparam logic [11:0] MISC_CTRL_ADDR = 12'h0e4;
    localparam logic [15:0] MISC_CTRL_RESET = 16'h0000;
    localparam logic [15:0] MISC_CTRL_WMASK = 16'h61c0;
    localparam int RSVD_TOP_BIT = 15;
    localparam int ALDO_PD_BIT = 14;
    localparam int CAL_X2_BIT = 13;
    localparam int ROUTE_BIT = 8;
    localparam int DIAG_BIT = 7;
    localparam int KEEP_GPO_BIT = 6;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic analog_regulator_powerdown;
        logic calibration_range_double;
        logic pin_drive;
        logic pin_oe;
        logic osc_run;
        logic diag_run;
    } misc_out_s;
endpackage

// ===== logic/pin_four_mux.sv
`timescale 1ns/1ps
module pin_four_mux (
    input wire logic route_en,
    input wire logic in_standby,
    input wire logic pin_four_output_enable,
    input wire logic pin_four_output_value,
    output logic oe,
    output logic value
);
    always_comb begin
        if (route_en) begin
            oe = 1'b1;
            value = ~in_standby;
        end else begin
            oe = pin_four_output_enable;
            value = pin_four_output_value;
        end
    end
endmodule

// ===== logic/misc_standby_control_register.sv
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Contract
// - Bit 14 powers down analog regulator.
// - Bit 13 doubles calibration string voltage.
// - Bit 8 overrides pin four output fields.
// - Routed pin four low during standby.
// - Routed pin four high while converting.
// - Unrouted pin four follows enable, value.
// - Bit 7 keeps enabled diagnostics in standby.
// - Bit 7 keeps oscillator in standby if voltage error, internal clock.
// - Otherwise oscillator stops in standby.
module misc_standby_control_register
    import misc_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic in_standby,
    input wire logic diag_enabled_any,
    input wire logic voltage_error_enabled,
    input wire logic internal_osc_selected,
    input wire logic pin_four_output_enable,
    input wire logic pin_four_output_value,
    output misc_out_s ctrl_out
);
    typedef struct packed {
        logic [15:0] reg_val;
        logic aw_got;
        logic [11:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awready;
        logic wready;
        logic arready;
        misc_out_s outs;
    } state_s;

    state_s st_q, st_d;
    logic mux_oe, mux_val;
    logic [15:0] wbytes;

    pin_four_mux u_mux (
        .route_en(st_q.reg_val[ROUTE_BIT]),
        .in_standby(in_standby),
        .pin_four_output_enable(pin_four_output_enable),
        .pin_four_output_value(pin_four_output_value),
        .oe(mux_oe),
        .value(mux_val)
    );

    always_comb begin
        st_d = st_q;
        wbytes = {{8{st_q.w_strb[1]}}, {8{st_q.w_strb[0]}}};
        if (s_axi_awvalid && !st_q.aw_got) begin
            st_d.aw_got = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_q.w_got) begin
            st_d.w_got = 1'b1;
            st_d.w_data = s_axi_wdata;
            st_d.w_strb = s_axi_wstrb;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            if (st_q.aw_addr[11:2] == MISC_CTRL_ADDR[11:2]) begin
                st_d.bresp = RESP_OKAY;
                // Bit 15 is never kept; software is expected to write it as zero.
                st_d.reg_val = (st_q.reg_val & ~(wbytes & MISC_CTRL_WMASK))
                    | (st_q.w_data[15:0] & wbytes & MISC_CTRL_WMASK);
            end else begin
                st_d.bresp = RESP_SLVERR;
            end
        end
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            if (s_axi_araddr[11:2] == MISC_CTRL_ADDR[11:2]) begin
                st_d.rdata = {16'h0000, st_q.reg_val};
                st_d.rresp = RESP_OKAY;
            end else begin
                st_d.rdata = 32'h0000_0000;
                st_d.rresp = RESP_SLVERR;
            end
        end else if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        st_d.outs.analog_regulator_powerdown = st_q.reg_val[ALDO_PD_BIT];
        st_d.outs.calibration_range_double = st_q.reg_val[CAL_X2_BIT];
        st_d.outs.pin_oe = mux_oe;
        st_d.outs.pin_drive = mux_val;
        st_d.outs.diag_run = diag_enabled_any
            && (!in_standby || st_q.reg_val[DIAG_BIT]);
        // Running clocks are costly in standby, so keep the oscillator only on demand.
        st_d.outs.osc_run = !in_standby
            || (st_q.reg_val[DIAG_BIT] && voltage_error_enabled
                && internal_osc_selected);
        if (srst) begin
            st_d = '0;
            st_d.reg_val = MISC_CTRL_RESET;
            st_d.outs.osc_run = 1'b1;
        end
        // Readies live in flops of their own, so no port is driven through a gate.
        st_d.awready = !st_d.aw_got;
        st_d.wready = !st_d.w_got;
        st_d.arready = !st_d.rvalid;
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign ctrl_out = st_q.outs;

    property p_rsvd_zero;
        @(posedge clk) disable iff (srst) st_q.reg_val[12:9] == 4'h0;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

    property p_aldo;
        @(posedge clk) disable iff (srst)
            ctrl_out.analog_regulator_powerdown == $past(st_q.reg_val[ALDO_PD_BIT]);
    endproperty
    a_aldo: assert property (p_aldo) else $error("regulator control mismatch");

    property p_cal;
        @(posedge clk) disable iff (srst)
            ctrl_out.calibration_range_double == $past(st_q.reg_val[CAL_X2_BIT]);
    endproperty
    a_cal: assert property (p_cal) else $error("calibration double mismatch");

    property p_route_oe;
        @(posedge clk) disable iff (srst) $past(st_q.reg_val[ROUTE_BIT]) |-> ctrl_out.pin_oe;
    endproperty
    a_route_oe: assert property (p_route_oe) else $error("routed pin not driven");

    property p_route_stby;
        @(posedge clk) disable iff (srst)
            ($past(st_q.reg_val[ROUTE_BIT]) && $past(in_standby)) |-> !ctrl_out.pin_drive;
    endproperty
    a_route_stby: assert property (p_route_stby) else $error("pin high in standby");

    property p_route_conv;
        @(posedge clk) disable iff (srst)
            ($past(st_q.reg_val[ROUTE_BIT]) && !$past(in_standby)) |-> ctrl_out.pin_drive;
    endproperty
    a_route_conv: assert property (p_route_conv) else $error("pin low converting");

    property p_gpo;
        @(posedge clk) disable iff (srst)
            !$past(st_q.reg_val[ROUTE_BIT]) |-> (ctrl_out.pin_oe == $past(pin_four_output_enable)
                && ctrl_out.pin_drive == $past(pin_four_output_value));
    endproperty
    a_gpo: assert property (p_gpo) else $error("pin four fields ignored");

    property p_diag;
        @(posedge clk) disable iff (srst)
            ($past(in_standby) && $past(diag_enabled_any)) |->
                ctrl_out.diag_run == $past(st_q.reg_val[DIAG_BIT]);
    endproperty
    a_diag: assert property (p_diag) else $error("standby diagnostics wrong");

    property p_osc;
        @(posedge clk) disable iff (srst)
            $past(in_standby) |-> ctrl_out.osc_run == ($past(st_q.reg_val[DIAG_BIT])
                && $past(voltage_error_enabled) && $past(internal_osc_selected));
    endproperty
    a_osc: assert property (p_osc) else $error("standby oscillator wrong");

    // A write goes in two steps: both halves held, then the answer one edge later.
    sequence s_wr_held;
        st_q.aw_got && st_q.w_got && !st_q.bvalid;
    endsequence

    sequence s_wr_answer;
        s_axi_bvalid && s_axi_awready && s_axi_wready;
    endsequence

    property p_wr_answer;
        @(posedge clk) disable iff (srst) s_wr_held |=> s_wr_answer;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");

    sequence s_wr_hit;
        st_q.aw_got && st_q.w_got && !st_q.bvalid && st_q.w_strb[1:0] == 2'b11
            && st_q.aw_addr[11:2] == MISC_CTRL_ADDR[11:2];
    endsequence

    property p_wr_lands;
        @(posedge clk) disable iff (srst)
            s_wr_hit |=> st_q.reg_val == ($past(st_q.w_data[15:0]) & MISC_CTRL_WMASK);
    endproperty
    a_wr_lands: assert property (p_wr_lands) else $error("write not stored");

    sequence s_wr_miss;
        st_q.aw_got && st_q.w_got && !st_q.bvalid
            && st_q.aw_addr[11:2] != MISC_CTRL_ADDR[11:2];
    endsequence

    property p_wr_refuse;
        @(posedge clk) disable iff (srst)
            s_wr_miss |=> (s_axi_bresp == RESP_SLVERR && $stable(st_q.reg_val));
    endproperty
    a_wr_refuse: assert property (p_wr_refuse) else $error("unmapped write accepted");

    property p_read_rsvd;
        @(posedge clk) disable iff (srst)
            (s_axi_rvalid && s_axi_rresp == RESP_OKAY)
                |-> (s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[12:9] == 4'h0);
    endproperty
    a_read_rsvd: assert property (p_read_rsvd) else $error("reserved read nonzero");
endmodule

// ===== testbench/test_misc_standby_control_register.sv
`timescale 1ns/1ps
module test_misc_standby_control_register;
import misc_ctrl_pkg::*;
logic clk = 0;
logic srst = 1;
logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
logic [31:0] s_axi_wdata = '0, s_axi_rdata;
logic [3:0] s_axi_wstrb = '0;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic in_standby = 0, diag_enabled_any = 0, voltage_error_enabled = 0;
logic internal_osc_selected = 0, pin_four_output_enable = 0, pin_four_output_value = 0;
misc_out_s ctrl_out;
int err_total = 0;
int num_checks = 0;
int cyc = 0;
logic [1:0] bq[$];
logic [33:0] rq[$];
misc_out_s oq[$];
logic [3:0] wr_strb = 4'hf;

misc_standby_control_register u_dut (.*);

initial begin
    forever #25 clk = ~clk;
end

task chk(input string n, input logic [33:0] e, input logic [33:0] s);
    num_checks++;
    if (s !== e) begin
        err_total++;
        $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
endtask
task cmp_b(input logic [1:0] e, input logic [1:0] s); chk("bresp", 34'(e), 34'(s)); endtask
task cmp_r(input logic [33:0] e, input logic [33:0] s); chk("rresp_rdata", e, s); endtask
task cmp_o(input misc_out_s e, input misc_out_s s); chk("ctrl_out", 34'(e), 34'(s)); endtask

task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
endtask

// Address and data are offered together and each is dropped as soon as it is taken.
// Handshakes are judged at the falling edge, where the flopped readies have settled.
task axi_wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    b_t = 0;
    bq.push_back(er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= wr_strb;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b_t) begin
        @(negedge clk);
        aw_t = s_axi_awvalid && s_axi_awready;
        w_t = s_axi_wvalid && s_axi_wready;
        b_t = s_axi_bvalid;
        @(posedge clk);
        if (aw_t) s_axi_awvalid <= 0;
        if (w_t) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
endtask

task axi_rd(input logic [11:0] a, input logic [33:0] ex);
    logic ar_t, r_t;
    r_t = 0;
    rq.push_back(ex);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!r_t) begin
        @(negedge clk);
        ar_t = s_axi_arvalid && s_axi_arready;
        r_t = s_axi_rvalid;
        @(posedge clk);
        if (ar_t) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
endtask

function automatic misc_out_s expo(input logic [15:0] r);
    misc_out_s o;
    o.analog_regulator_powerdown = r[14];
    o.calibration_range_double = r[13];
    o.pin_oe = r[8] | pin_four_output_enable;
    o.pin_drive = r[8] ? !in_standby : pin_four_output_value;
    o.osc_run = !in_standby | (r[7] & voltage_error_enabled & internal_osc_selected);
    o.diag_run = diag_enabled_any & (!in_standby | r[7]);
    return o;
endfunction

// Results are looked at in mid-cycle, away from the edges that launch them.
always @(negedge clk) begin
    if (s_axi_bvalid && s_axi_bready) cmp_b(bq.pop_front(), s_axi_bresp);
    if (s_axi_rvalid && s_axi_rready) cmp_r(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (oq.size() > 0) begin
        cmp_o(oq.pop_front(), ctrl_out);
    end
    cyc++;
    if (cyc == 5000) begin
        err_total++;
        give_verdict();
    end
end

initial begin
    logic [15:0] v;
    void'($urandom(32'h8ec7b535));
    repeat (8) @(posedge clk);
    srst <= 0;
    axi_rd(MISC_CTRL_ADDR, {RESP_OKAY, 32'h0000_0000});
    oq.push_back(expo(16'h0000));
    $display("reset test done");
    axi_wr(12'h0e0, 16'h6180, RESP_SLVERR);
    axi_rd(12'h0e8, {RESP_SLVERR, 32'h0000_0000});
    axi_rd(MISC_CTRL_ADDR, {RESP_OKAY, 32'h0000_0000});
    $display("unmapped test done");
    // Bit six of the count forces the routing bit, so each routed and standby case appears.
    for (int i = 0; i < 128; i++) begin
        v = 16'($urandom()) & 16'h7fff;
        v[ROUTE_BIT] = i[6];
        @(posedge clk);
        {in_standby, diag_enabled_any, voltage_error_enabled} <= 3'(i >> 3);
        {internal_osc_selected, pin_four_output_enable, pin_four_output_value} <= 3'(i);
        axi_wr(MISC_CTRL_ADDR, v, RESP_OKAY);
        axi_rd(MISC_CTRL_ADDR, {RESP_OKAY, 16'h0000, v & MISC_CTRL_WMASK});
        repeat (2) @(posedge clk);
        oq.push_back(expo(v));
    end
    $display("field and pin test done");
    // Each strobe reaches only its own byte; the upper two strobes are ignored.
    axi_wr(MISC_CTRL_ADDR, 16'h0000, RESP_OKAY);
    wr_strb = 4'h1;
    axi_wr(MISC_CTRL_ADDR, 16'h7fff, RESP_OKAY);
    axi_rd(MISC_CTRL_ADDR, {RESP_OKAY, 32'h0000_00c0});
    wr_strb = 4'h2;
    axi_wr(MISC_CTRL_ADDR, 16'h7fff, RESP_OKAY);
    axi_rd(MISC_CTRL_ADDR, {RESP_OKAY, 32'h0000_61c0});
    wr_strb = 4'hc;
    axi_wr(MISC_CTRL_ADDR, 16'h0000, RESP_OKAY);
    axi_rd(MISC_CTRL_ADDR, {RESP_OKAY, 32'h0000_61c0});
    wr_strb = 4'hf;
    $display("strobe test done");
    repeat (2) @(posedge clk);
    give_verdict();
end
endmodule
